/* hdl/spe_event_status.sv */
// event status, interrupt mask and mode bits of a serial port
// assumes: framer and dma flags arrive on i_ref_clk; modem lines and rx pin are async
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// - repeat limit field sets max repetitions in smartcard T=0 mode
// - filter off passes rx line; on uses 2-of-3 vote at 1/16 bit
// - write-only enable register: bits 0-13 events, 16-19 modem changes
// - write-only disable register with same layout
// - read-only mask register reports enabled sources
// - rx ready set while unread character, cleared by read or rx disable
// - rx ready returns when receiver re-enabled with pending character
// - tx ready low with held char, break request, or tx disabled
// - tx ready rises as soon as transmitter enabled
// - break flag latches until status-reset command
// - dma end-of-transfer flags follow channel signals unlatched
// - overrun flag latches until status-reset command
// - framing flag latches on low stop bit until status-reset
// - parity flag latches until status-reset command
// - timeout flag set after timeout since arm, zero if timeout value zero
// - tx empty only when holding and shift registers both empty
// - repeat flag latches until clear-repeat-count command
// - dma buffer flags mirror channel signals unlatched
// - nak flag latches until clear-nak command
// - modem change flag set on transition, cleared by status read
// - status shows live modem line levels
// - status-reset clears parity, framing, overrun and break together
// - arm command clears timeout flag
`timescale 1ns/1ps
`include "spe_cfg.svh"

module spe_event_status
    import spe_pkg::*;
#(
    parameter int ITER_W = `SPE_MODE_ITER_W
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire spe_live_t i_live,
    input wire spe_events_t i_events,
    input wire spe_cmds_t i_cmds,
    input wire logic i_timeout_value_zero,
    input wire spe_modem_t i_modem_pins,
    input wire logic i_rx_pin,
    input wire logic i_tick16,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic o_rx_filtered,
    output logic [ITER_W-1:0] o_max_iteration,
    output logic o_filter_en
);

    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    logic [3:0] modem_s1_reg;
    logic [3:0] modem_s2_reg;
    logic [3:0] modem_old_reg;
    logic rx_s1_reg;
    logic rx_s2_reg;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            modem_s1_reg <= 4'h0;
            modem_s2_reg <= 4'h0;
            modem_old_reg <= 4'h0;
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
        end else begin
            modem_s1_reg <= i_modem_pins;
            modem_s2_reg <= modem_s1_reg;
            modem_old_reg <= modem_s2_reg;
            rx_s1_reg <= i_rx_pin;
            rx_s2_reg <= rx_s1_reg;
        end
    end

    //------------------------------------------------------------
    // bus decode
    //------------------------------------------------------------
    wire logic wr_set = i_wr && (i_addr == `SPE_OFF_ENABLE_SET);
    wire logic wr_clr = i_wr && (i_addr == `SPE_OFF_ENABLE_CLEAR);
    wire logic wr_mode = i_wr && (i_addr == `SPE_OFF_MODE);
    wire logic rd_flags = i_rd && (i_addr == `SPE_OFF_CHANNEL_FLAGS);
    wire logic rd_view = i_rd && (i_addr == `SPE_OFF_ENABLE_VIEW);
    wire logic rd_mode = i_rd && (i_addr == `SPE_OFF_MODE);

    //------------------------------------------------------------
    // mode bits
    //------------------------------------------------------------
    logic [ITER_W-1:0] max_iter_reg;
    logic filter_reg;
    wire logic [ITER_W-1:0] iter_field = i_wdata[`SPE_MODE_ITER_LSB +: ITER_W];
    wire logic filter_field = i_wdata[`SPE_MODE_FILTER_BIT];
    wire logic [31:0] mode_word = (32'(filter_reg) << `SPE_MODE_FILTER_BIT)
        | (32'(max_iter_reg) << `SPE_MODE_ITER_LSB);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            max_iter_reg <= '0;
            filter_reg <= 1'b0;
        end else if (wr_mode) begin
            max_iter_reg <= iter_field;
            filter_reg <= filter_field;
        end
    end

    //------------------------------------------------------------
    // receive line filter
    //------------------------------------------------------------
    // three samples taken on the sixteenth-bit tick, majority decides
    logic [2:0] rx_samp_reg;
    logic rx_filt_reg;

    function automatic logic spe_major(input logic [2:0] s);
        return (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
    endfunction

    wire logic [2:0] rx_samp_next = i_tick16 ? {rx_samp_reg[1:0], rx_s2_reg} : rx_samp_reg;
    wire logic rx_filt_next = filter_reg ? spe_major(rx_samp_next) : rx_s2_reg;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_samp_reg <= 3'h7;
            rx_filt_reg <= 1'b1;
        end else begin
            rx_samp_reg <= rx_samp_next;
            rx_filt_reg <= rx_filt_next;
        end
    end

    //------------------------------------------------------------
    // interrupt mask
    //------------------------------------------------------------
    logic [31:0] mask_reg;
    // clear beats set when both written the same cycle, which cannot happen: strobes differ by address
    wire logic [31:0] mask_next = (mask_reg | (wr_set ? i_wdata : 32'h0))
        & ~(wr_clr ? i_wdata : 32'h0) & `SPE_EVENT_MASK;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mask_reg <= `SPE_MASK_RESET;
        end else begin
            mask_reg <= mask_next;
        end
    end

    //------------------------------------------------------------
    // sticky flags
    //------------------------------------------------------------
    // an event in the clearing cycle survives the clear
    logic brk_reg;
    logic ovr_reg;
    logic frame_reg;
    logic par_reg;
    logic tmo_reg;
    logic iter_reg;
    logic nak_reg;
    logic [3:0] chg_reg;

    wire logic clr_err = i_cmds.clear_error_flags_cmd;
    wire logic brk_next = i_events.brk | (brk_reg & ~clr_err);
    wire logic ovr_next = i_events.ovr | (ovr_reg & ~clr_err);
    wire logic frame_next = i_events.frame | (frame_reg & ~clr_err);
    wire logic par_next = i_events.par | (par_reg & ~clr_err);
    // a zero timeout value disables the timer, so the flag reads zero
    wire logic tmo_next = ~i_timeout_value_zero
        & (i_events.tmo | (tmo_reg & ~i_cmds.arm_idle_timer_cmd));
    wire logic iter_next = i_events.iter_hit | (iter_reg & ~i_cmds.clear_repeat_count_cmd);
    wire logic nak_next = i_events.nak | (nak_reg & ~i_cmds.clear_nak_flag_cmd);
    wire logic [3:0] chg_edge = modem_s2_reg ^ modem_old_reg;
    wire logic [3:0] chg_next = chg_edge | (chg_reg & {4{~rd_flags}});

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            brk_reg <= 1'b0;
            ovr_reg <= 1'b0;
            frame_reg <= 1'b0;
            par_reg <= 1'b0;
            tmo_reg <= 1'b0;
            iter_reg <= 1'b0;
            nak_reg <= 1'b0;
            chg_reg <= 4'h0;
        end else begin
            brk_reg <= brk_next;
            ovr_reg <= ovr_next;
            frame_reg <= frame_next;
            par_reg <= par_next;
            tmo_reg <= tmo_next;
            iter_reg <= iter_next;
            nak_reg <= nak_next;
            chg_reg <= chg_next;
        end
    end

    //------------------------------------------------------------
    // status word and interrupt
    //------------------------------------------------------------
    // live flags come from the framer, which already folds in enable and break state
    logic [31:0] status;
    always_comb begin
        status = 32'h0;
        status[`SPE_BIT_RX_CHAR_READY] = i_live.rx_char_ready;
        status[`SPE_BIT_TX_HOLDING_FREE] = i_live.tx_holding_free;
        status[`SPE_BIT_BRK] = brk_reg;
        status[`SPE_BIT_RX_DMA_TRANSFER_DONE] = i_live.rx_dma_transfer_done;
        status[`SPE_BIT_TX_DMA_TRANSFER_DONE] = i_live.tx_dma_transfer_done;
        status[`SPE_BIT_OVR] = ovr_reg;
        status[`SPE_BIT_FRAME] = frame_reg;
        status[`SPE_BIT_PAR] = par_reg;
        status[`SPE_BIT_TMO] = tmo_reg;
        status[`SPE_BIT_TX_ALL_DRAINED] = i_live.tx_all_drained;
        status[`SPE_BIT_ITER] = iter_reg;
        status[`SPE_BIT_TX_DMA_BUFFER_DRAINED] = i_live.tx_dma_buffer_drained;
        status[`SPE_BIT_RX_DMA_BUFFER_FULL] = i_live.rx_dma_buffer_full;
        status[`SPE_BIT_NAK] = nak_reg;
        status[`SPE_BIT_CHG_LSB +: 4] = chg_reg;
        status[`SPE_BIT_LVL_LSB +: 4] = modem_s2_reg;
    end

    wire logic irq_next = |(status & mask_reg);

    wire logic [31:0] rdata_next =
        rd_view ? mask_reg :
        rd_flags ? status :
        rd_mode ? mode_word :
        32'h0;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h0;
            o_irq <= 1'b0;
        end else begin
            o_rdata <= rdata_next;
            o_irq <= irq_next;
        end
    end

    assign o_rx_filtered = rx_filt_reg;
    assign o_max_iteration = max_iter_reg;
    assign o_filter_en = filter_reg;

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    sequence s_enable_write;
        wr_set && i_wdata[0];
    endsequence
    sequence s_mask_up;
        ##1 mask_reg[0];
    endsequence

    a_enable_sets_mask: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_enable_write |-> s_mask_up) else $error("enable write did not set mask");
    a_disable_clr_mask: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_clr && i_wdata[5] |=> !mask_reg[5]) else $error("disable write did not clear mask");
    a_mask_view_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_rd && i_addr == `SPE_OFF_ENABLE_VIEW |=> o_rdata == $past(mask_reg)) else $error("mask read wrong");
    a_overrun_sticky: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_events.ovr ##1 !clr_err [*3] |-> ovr_reg) else $error("overrun flag lost");
    a_status_reset_all: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        clr_err && !i_events.par && !i_events.frame && !i_events.ovr && !i_events.brk
        |=> !par_reg && !frame_reg && !ovr_reg && !brk_reg) else $error("status reset failed");
    a_nak_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_cmds.clear_nak_flag_cmd && !i_events.nak |=> !nak_reg) else $error("nak not cleared");
    a_timeout_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_timeout_value_zero |=> !tmo_reg) else $error("timeout flag with zero value");
    a_change_seen: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $changed(modem_s2_reg[0]) |=> chg_reg[0]) else $error("modem change missed");
    a_irq_follows: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        ovr_reg && mask_reg[5] |=> o_irq) else $error("interrupt missing");
    a_filter_off_pass: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !filter_reg |=> o_rx_filtered == $past(rx_s2_reg)) else $error("unfiltered rx wrong");

    sequence s_status_read;
        rd_flags;
    endsequence

    // register side: mask and mode writes, mode read, and receive filter hold
    a_enable_modem_bit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_set && i_wdata[`SPE_BIT_CHG_LSB] |=> mask_reg[`SPE_BIT_CHG_LSB]) else $error("modem enable missed");
    a_disable_modem_bit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_clr && i_wdata[`SPE_BIT_CHG_LSB + 3] |=> !mask_reg[`SPE_BIT_CHG_LSB + 3]) else $error("modem disable missed");
    a_set_zero_keeps: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_set && i_wdata == 32'h0 |=> $stable(mask_reg)) else $error("zero enable write changed mask");
    a_clr_zero_keeps: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_clr && i_wdata == 32'h0 |=> $stable(mask_reg)) else $error("zero disable write changed mask");
    a_iter_field_load: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_mode |=> o_max_iteration == $past(iter_field)) else $error("repeat limit not loaded");
    a_filter_load: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_mode |=> o_filter_en == $past(filter_field)) else $error("filter setting not loaded");
    a_mode_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        rd_mode |=> o_rdata[`SPE_MODE_ITER_LSB +: ITER_W] == $past(max_iter_reg)
        && o_rdata[`SPE_MODE_FILTER_BIT] == $past(filter_reg)) else $error("mode read wrong");
    a_filter_high_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        filter_reg && rx_samp_reg == 3'h7 && !i_tick16 |=> o_rx_filtered) else $error("filter lost high");
    a_filter_low_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        filter_reg && rx_samp_reg == 3'h0 && !i_tick16 |=> !o_rx_filtered) else $error("filter lost low");

    // status read carries the live inputs of the read cycle
    a_rx_ready_mirror: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_status_read |=> o_rdata[`SPE_BIT_RX_CHAR_READY] == $past(i_live.rx_char_ready)) else $error("rx ready wrong");
    a_tx_ready_mirror: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_status_read |=> o_rdata[`SPE_BIT_TX_HOLDING_FREE] == $past(i_live.tx_holding_free)) else $error("tx ready wrong");
    a_dma_end_mirror: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_status_read |=> o_rdata[`SPE_BIT_RX_DMA_TRANSFER_DONE] == $past(i_live.rx_dma_transfer_done)
        && o_rdata[`SPE_BIT_TX_DMA_TRANSFER_DONE] == $past(i_live.tx_dma_transfer_done)) else $error("dma end flags wrong");
    a_tx_empty_mirror: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_status_read |=> o_rdata[`SPE_BIT_TX_ALL_DRAINED] == $past(i_live.tx_all_drained)) else $error("tx empty wrong");
    a_dma_buf_mirror: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_status_read |=> o_rdata[`SPE_BIT_TX_DMA_BUFFER_DRAINED] == $past(i_live.tx_dma_buffer_drained)
        && o_rdata[`SPE_BIT_RX_DMA_BUFFER_FULL] == $past(i_live.rx_dma_buffer_full)) else $error("dma buffer flags wrong");
    a_level_image: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_status_read |=> o_rdata[`SPE_BIT_LVL_LSB +: 4] == $past(modem_s2_reg)) else $error("modem levels wrong");

    // sticky flags: an event sets, only the matching command (a status read for modem changes) clears; a zero timeout value also clears timeout
    a_break_set: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_events.brk |=> brk_reg) else $error("break not latched");
    a_break_sticky: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        brk_reg && !clr_err |=> brk_reg) else $error("break flag lost");
    a_frame_latch: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_events.frame |=> frame_reg) else $error("framing error not latched");
    a_parity_latch: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_events.par |=> par_reg) else $error("parity error not latched");
    a_timeout_set: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_events.tmo && !i_timeout_value_zero |=> tmo_reg) else $error("timeout not latched");
    a_timeout_arm: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_cmds.arm_idle_timer_cmd && !i_events.tmo |=> !tmo_reg) else $error("arm did not clear timeout");
    a_repeat_sticky: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        iter_reg && !i_cmds.clear_repeat_count_cmd |=> iter_reg) else $error("repeat flag lost");
    a_repeat_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_cmds.clear_repeat_count_cmd && !i_events.iter_hit |=> !iter_reg) else $error("repeat flag not cleared");
    a_nak_sticky: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        nak_reg && !i_cmds.clear_nak_flag_cmd |=> nak_reg) else $error("nak flag lost");
    a_change_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        rd_flags && chg_edge == 4'h0 |=> chg_reg == 4'h0) else $error("status read kept change flags");
    a_change_other: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $changed(modem_s2_reg[2]) |=> chg_reg[2]) else $error("carrier change missed");

    // interrupt line
    a_irq_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (status & mask_reg) == 32'h0 |=> !o_irq) else $error("interrupt without masked flag");

endmodule

/* hdl/spe_cfg.svh */
// register offsets, field positions and reset values of the event status block
// assumes: included by its bare name, defines only
`ifndef SPE_CFG_SVH
`define SPE_CFG_SVH
`define SPE_OFF_ENABLE_SET 8'h08
`define SPE_OFF_ENABLE_CLEAR 8'h0C
`define SPE_OFF_ENABLE_VIEW 8'h10
`define SPE_OFF_CHANNEL_FLAGS 8'h14
`define SPE_OFF_MODE 8'h04
`define SPE_MODE_ITER_LSB 24
`define SPE_MODE_ITER_W 3
`define SPE_MODE_FILTER_BIT 28
`define SPE_EVENT_MASK 32'h000F3FFF
`define SPE_MASK_RESET 32'h00000000
`define SPE_MODE_RESET 32'h00000000
`define SPE_BIT_RX_CHAR_READY 0
`define SPE_BIT_TX_HOLDING_FREE 1
`define SPE_BIT_BRK 2
`define SPE_BIT_RX_DMA_TRANSFER_DONE 3
`define SPE_BIT_TX_DMA_TRANSFER_DONE 4
`define SPE_BIT_OVR 5
`define SPE_BIT_FRAME 6
`define SPE_BIT_PAR 7
`define SPE_BIT_TMO 8
`define SPE_BIT_TX_ALL_DRAINED 9
`define SPE_BIT_ITER 10
`define SPE_BIT_TX_DMA_BUFFER_DRAINED 11
`define SPE_BIT_RX_DMA_BUFFER_FULL 12
`define SPE_BIT_NAK 13
`define SPE_BIT_CHG_LSB 16
`define SPE_BIT_LVL_LSB 20
`endif

/* hdl/spe_pkg.sv */
// types shared by the event status block
// assumes: compiled before the module
package spe_pkg;
    // one-cycle event pulses from the character framer
    typedef struct packed {
        logic brk;
        logic ovr;
        logic frame;
        logic par;
        logic tmo;
        logic nak;
        logic iter_hit;
    } spe_events_t;
    // live state of the framer and dma channels
    typedef struct packed {
        logic rx_char_ready;
        logic tx_holding_free;
        logic tx_all_drained;
        logic rx_dma_transfer_done;
        logic tx_dma_transfer_done;
        logic tx_dma_buffer_drained;
        logic rx_dma_buffer_full;
    } spe_live_t;
    // one-cycle control commands
    typedef struct packed {
        logic clear_error_flags_cmd;
        logic arm_idle_timer_cmd;
        logic clear_nak_flag_cmd;
        logic clear_repeat_count_cmd;
    } spe_cmds_t;
    // modem line order: alert, peer_set_ok, carrier_sense, peer_accepts
    typedef logic [3:0] spe_modem_t;
endpackage

/* sim/spe_far_model.sv */
// framer, dma channel and modem-line stand-in for the event status block
// assumes: bench drives the request inputs on the rising edge of i_ref_clk
`timescale 1ns/1ps
module spe_far_model
    import spe_pkg::*;
#(
    parameter int TICK_DIV = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire spe_events_t i_ev_req,
    input wire spe_cmds_t i_cmd_req,
    input wire spe_live_t i_live_req,
    input wire spe_modem_t i_modem_req,
    input wire logic i_rx_req,
    output spe_events_t o_events,
    output spe_cmds_t o_cmds,
    output spe_live_t o_live,
    output spe_modem_t o_modem,
    output logic o_rx,
    output logic o_tick16
);
    logic [7:0] tick_cnt_reg;
    // all outputs launched from flops, like the real framer, so pulses are one clean cycle
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_events <= '0;
            o_cmds <= '0;
            o_live <= '0;
            o_modem <= '0;
            o_rx <= 1'b1;
            o_tick16 <= 1'b0;
            tick_cnt_reg <= 8'h00;
        end else begin
            o_events <= i_ev_req;
            o_cmds <= i_cmd_req;
            o_live <= i_live_req;
            o_modem <= i_modem_req;
            o_rx <= i_rx_req;
            o_tick16 <= (tick_cnt_reg == 8'h00);
            tick_cnt_reg <= (tick_cnt_reg == 8'(TICK_DIV - 1)) ? 8'h00 : tick_cnt_reg + 8'h01;
        end
    end
endmodule

/* sim/test_spe_event_status.sv */
// self-checking bench of the event status block
// assumes: far model turns bench requests into framer and dma signals
`timescale 1ns/1ps
`include "spe_cfg.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); n_mismatch++; end end
module test_spe_event_status;
    import spe_pkg::*;
    typedef struct {logic [6:0] ev; logic [6:0] lv; logic [3:0] clr; int pos;} spe_row_t;
    localparam logic [7:0] A_SET = `SPE_OFF_ENABLE_SET;
    localparam logic [7:0] A_CLR = `SPE_OFF_ENABLE_CLEAR;
    localparam logic [7:0] A_VIEW = `SPE_OFF_ENABLE_VIEW;
    localparam logic [7:0] A_STAT = `SPE_OFF_CHANNEL_FLAGS;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd_s = 1'b0, tz = 1'b0, rx_req = 1'b1, irq, rxf, fen, low;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic [2:0] iter;
    logic [6:0] ev_req = '0, lv_req = '0;
    logic [3:0] cmd_req = '0, modem_req = '0;
    spe_events_t ev;
    spe_cmds_t cmd;
    spe_live_t live;
    spe_modem_t modem;
    logic rx, tick;
    int n_tests = 0, n_mismatch = 0, cyc = 0;
    spe_row_t rows[14] = '{'{7'h40, 7'h00, 4'h8, 2}, '{7'h20, 7'h00, 4'h8, 5}, '{7'h10, 7'h00, 4'h8, 6},
        '{7'h08, 7'h00, 4'h8, 7}, '{7'h04, 7'h00, 4'h4, 8}, '{7'h02, 7'h00, 4'h2, 13},
        '{7'h01, 7'h00, 4'h1, 10}, '{7'h00, 7'h40, 4'h0, 0}, '{7'h00, 7'h20, 4'h0, 1},
        '{7'h00, 7'h10, 4'h0, 9}, '{7'h00, 7'h08, 4'h0, 3}, '{7'h00, 7'h04, 4'h0, 4},
        '{7'h00, 7'h02, 4'h0, 11}, '{7'h00, 7'h01, 4'h0, 12}};
    always #10 clk = ~clk;
    spe_far_model spe_far_model_i (.i_ref_clk(clk), .i_rst(rst), .i_ev_req(spe_events_t'(ev_req)),
        .i_cmd_req(spe_cmds_t'(cmd_req)), .i_live_req(spe_live_t'(lv_req)), .i_modem_req(modem_req),
        .i_rx_req(rx_req), .o_events(ev), .o_cmds(cmd), .o_live(live), .o_modem(modem), .o_rx(rx),
        .o_tick16(tick));
    spe_event_status spe_event_status_i (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd_s), .i_live(live), .i_events(ev), .i_cmds(cmd), .i_timeout_value_zero(tz),
        .i_modem_pins(modem), .i_rx_pin(rx), .i_tick16(tick), .o_rdata(rdata), .o_irq(irq),
        .o_rx_filtered(rxf), .o_max_iteration(iter), .o_filter_en(fen));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // the watchdog cuts a hang short well beyond the roughly 500 cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic bw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic br(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 `CHK(nm, e, rdata)
    endtask
    // one-cycle event and command pulses; live levels are held until changed
    task automatic stim(input logic [6:0] e, input logic [3:0] c, input logic [6:0] l);
        @(posedge clk);
        ev_req <= e;
        cmd_req <= c;
        lv_req <= l;
        @(posedge clk);
        ev_req <= '0;
        cmd_req <= '0;
        repeat (2) @(posedge clk);
    endtask
    task automatic glitch(input int len);
        low = 1'b0;
        @(posedge clk);
        rx_req <= 1'b0;
        for (int i = 0; i < len + 20; i++) begin
            @(posedge clk);
            if (i == len) rx_req <= 1'b1;
            #1 if (rxf === 1'b0) low = 1'b1;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1 `CHK("irq rst", 1'b0, irq)
        `CHK("rxf rst", 1'b1, rxf)
        br("view rst", A_VIEW, 32'h00000000);
        br("stat rst", A_STAT, 32'h00000000);
        foreach (rows[r]) begin
            bw(A_SET, 32'h00000001 << rows[r].pos);
            stim(rows[r].ev, 4'h0, rows[r].lv);
            br("stat set", A_STAT, 32'h00000001 << rows[r].pos);
            `CHK("irq on", 1'b1, irq)
            stim(7'h00, 4'h0, 7'h00);
            br("stat hold", A_STAT, (rows[r].ev != 0) ? 32'h00000001 << rows[r].pos : 32'h0);
            stim(7'h00, rows[r].clr, 7'h00);
            br("stat clr", A_STAT, 32'h00000000);
            `CHK("irq off", 1'b0, irq)
            bw(A_CLR, 32'hFFFFFFFF);
        end
        bw(A_SET, 32'hFFFFFFFF);
        br("view all", A_VIEW, `SPE_EVENT_MASK);
        bw(A_CLR, 32'h00003FFF);
        bw(A_SET, 32'h00000000);
        br("view part", A_VIEW, 32'h000F0000);
        bw(A_CLR, 32'h00000000);
        bw(8'h7C, 32'hFFFFFFFF);
        br("unmapped", 8'h7C, 32'h00000000);
        br("view keep", A_VIEW, 32'h000F0000);
        bw(A_CLR, 32'hFFFFFFFF);
        stim(7'h7A, 4'h0, 7'h00);
        br("errs", A_STAT, 32'h000020E4);
        stim(7'h00, 4'h8, 7'h00);
        br("errs clr", A_STAT, 32'h00002000);
        stim(7'h00, 4'h2, 7'h00);
        stim(7'h04, 4'h4, 7'h00);
        br("set wins", A_STAT, 32'h00000100);
        tz <= 1'b1;
        stim(7'h04, 4'h4, 7'h00);
        br("tmo zero", A_STAT, 32'h00000000);
        tz <= 1'b0;
        stim(7'h00, 4'h4, 7'h00);
        modem_req <= 4'h5;
        repeat (6) @(posedge clk);
        br("modem chg", A_STAT, 32'h00550000);
        br("modem rd", A_STAT, 32'h00500000);
        bw(`SPE_OFF_MODE, 32'h15000000);
        #1 `CHK("max iter", 3'h5, iter)
        `CHK("filt en", 1'b1, fen)
        br("mode rd", `SPE_OFF_MODE, 32'h15000000);
        // four low cycles meet exactly one sample tick, so the vote stays high
        glitch(3);
        `CHK("filt glitch", 1'b0, low)
        glitch(20);
        `CHK("filt long", 1'b1, low)
        bw(`SPE_OFF_MODE, 32'h00000000);
        glitch(4);
        `CHK("raw glitch", 1'b1, low)
        bw(A_SET, 32'h00000002);
        bw(`SPE_OFF_MODE, 32'h17000000);
        stim(7'h00, 4'h0, 7'h20);
        #1 `CHK("irq pre", 1'b1, irq)
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1 `CHK("irq mid rst", 1'b0, irq)
        `CHK("iter mid rst", 3'h0, iter)
        `CHK("filt mid rst", 1'b0, fen)
        br("view mid rst", A_VIEW, 32'h00000000);
        print_verdict();
    end
endmodule
